// *** tcaec_timer_channel_ctrl.v ***
/*
 * per-channel output compare action, channel 7 sharing, input capture
 * edge selection and interrupt gating for an eight-channel timer, with
 * an axi4-lite register slave.
 * assumes the counter and comparators sit outside and pulse the compare
 * match inputs; pins are synchronous to aclk.
 */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tcaec_defines.vh"

module tcaec_timer_channel_ctrl #(
    parameter NCH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [NCH-1:0] compare_match,
    input wire [NCH-1:0] counter_overflow,
    input wire [NCH-1:0] channel_pin_in,
    input wire [NCH-1:0] port_data_out,
    input wire [NCH-1:0] port_dir_out,
    output wire [NCH-1:0] channel_pin_out,
    output wire [NCH-1:0] channel_pin_oe,
    output reg [NCH-1:0] capture_event,
    output wire [NCH-1:0] channel_irq
);
    reg [7:0] compare_action_ctrl_hi_reg;
    reg [7:0] compare_action_ctrl_lo_reg;
    reg [7:0] capture_edge_ctrl_hi_reg;
    reg [7:0] capture_edge_ctrl_lo_reg;
    reg [7:0] channel_irq_enable_reg;
    reg [7:0] capture_compare_select_reg;
    reg [7:0] ch7_compare_mask_reg;
    reg [7:0] ch7_compare_data_reg;
    reg [7:0] compare_pin_disconnect_reg;
    reg [7:0] overflow_toggle_reg;
    reg [7:0] channel_flag_reg;
    reg [7:0] compare_channel_output_reg;
    reg [7:0] pin_prev_reg;
    reg [7:0] compare_channel_output_next;
    reg [7:0] channel_flag_next;
    reg [7:0] capture_next;
    reg [7:0] flag_clear;
    reg [15:0] act_pairs;
    reg [15:0] edge_pairs;
    reg [1:0] act;
    reg [1:0] edg;
    reg own_hit;
    reg ch7_hit;
    reg rise;
    reg fall;
    integer i;

    // write channel: address and data latched independently
    reg aw_held_reg;
    reg w_held_reg;
    reg [3:0] aw_idx_reg;
    reg aw_ok_reg;
    reg [7:0] w_byte_reg;
    reg w_lane_reg;
    wire do_write;
    wire [3:0] wr_idx;
    wire wr_ok;
    wire [7:0] wr_byte;
    wire wr_lane;

    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
    assign wr_idx = aw_held_reg ? aw_idx_reg : s_axi_awaddr[5:2];
    assign wr_ok = aw_held_reg ? aw_ok_reg : (s_axi_awaddr[1:0] == 2'b00);
    assign wr_byte = w_held_reg ? w_byte_reg : s_axi_wdata[7:0];
    assign wr_lane = w_held_reg ? w_lane_reg : s_axi_wstrb[0];
    assign do_write = (aw_held_reg | (s_axi_awvalid & s_axi_awready)) &
                      (w_held_reg | (s_axi_wvalid & s_axi_wready));

    function is_mapped;
        input [3:0] idx;
        begin
            is_mapped = (idx <= `TCAEC_IDX_STATUS) ||
                        (idx >= `TCAEC_IDX_ACT_HI &&
                         idx <= `TCAEC_IDX_IRQ_EN);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_idx_reg <= 4'h0;
            aw_ok_reg <= 1'b0;
            w_byte_reg <= `TCAEC_RST_BYTE;
            w_lane_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCAEC_RESP_OKAY;
        end else begin
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ok && is_mapped(wr_idx)) ?
                               `TCAEC_RESP_OKAY : `TCAEC_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_reg <= 1'b1;
                    aw_idx_reg <= s_axi_awaddr[5:2];
                    aw_ok_reg <= (s_axi_awaddr[1:0] == 2'b00);
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_reg <= 1'b1;
                    w_byte_reg <= s_axi_wdata[7:0];
                    w_lane_reg <= s_axi_wstrb[0];
                end
                if (s_axi_bvalid && s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire wen;
    assign wen = do_write & wr_ok & wr_lane;

    // control registers, all readable and writable at any time
    always @(posedge aclk) begin
        if (!aresetn) begin
            compare_action_ctrl_hi_reg <= `TCAEC_RST_BYTE;
            compare_action_ctrl_lo_reg <= `TCAEC_RST_BYTE;
            capture_edge_ctrl_hi_reg <= `TCAEC_RST_BYTE;
            capture_edge_ctrl_lo_reg <= `TCAEC_RST_BYTE;
            channel_irq_enable_reg <= `TCAEC_RST_BYTE;
            capture_compare_select_reg <= `TCAEC_RST_BYTE;
            ch7_compare_mask_reg <= `TCAEC_RST_BYTE;
            ch7_compare_data_reg <= `TCAEC_RST_BYTE;
            compare_pin_disconnect_reg <= `TCAEC_RST_BYTE;
            overflow_toggle_reg <= `TCAEC_RST_BYTE;
        end else if (wen) begin
            case (wr_idx)
                `TCAEC_IDX_ACT_HI: compare_action_ctrl_hi_reg <= wr_byte;
                `TCAEC_IDX_ACT_LO: compare_action_ctrl_lo_reg <= wr_byte;
                `TCAEC_IDX_EDGE_HI: capture_edge_ctrl_hi_reg <= wr_byte;
                `TCAEC_IDX_EDGE_LO: capture_edge_ctrl_lo_reg <= wr_byte;
                `TCAEC_IDX_IRQ_EN: channel_irq_enable_reg <= wr_byte;
                `TCAEC_IDX_SELECT: capture_compare_select_reg <= wr_byte;
                `TCAEC_IDX_CH7_MASK: ch7_compare_mask_reg <= wr_byte;
                `TCAEC_IDX_CH7_DATA: ch7_compare_data_reg <= wr_byte;
                `TCAEC_IDX_PIN_DISC: compare_pin_disconnect_reg <= wr_byte;
                `TCAEC_IDX_TOGGLE: overflow_toggle_reg <= wr_byte;
                default: ;
            endcase
        end
    end

    // event vectors seen by the per-channel loop
    wire [NCH-1:0] cmp_event;
    wire [NCH-1:0] ovf_toggle_hit;
    wire [NCH-1:0] capture_mode;
    assign cmp_event = compare_match & capture_compare_select_reg;
    assign ovf_toggle_hit = counter_overflow & overflow_toggle_reg &
                            capture_compare_select_reg;
    assign capture_mode = ~capture_compare_select_reg;

    // own action on own match: a channel masked to ch7 keeps it only
    // while ch7 is masked too; ch7 loses it whenever it is masked
    reg [NCH-1:0] own_allowed;
    integer k;
    always @* begin
        own_allowed = {NCH{1'b0}};
        for (k = 0; k < NCH; k = k + 1) begin
            if (!capture_compare_select_reg[k]) begin
                own_allowed[k] = 1'b0;
            end else if (!ch7_compare_mask_reg[k]) begin
                own_allowed[k] = 1'b1;
            end else if (k == NCH - 1) begin
                own_allowed[k] = 1'b0;
            end else begin
                own_allowed[k] = ch7_compare_mask_reg[NCH-1];
            end
        end
    end

    // ch7 event reaches masked channels only when both are compares
    reg [NCH-1:0] ch7_shared;
    integer n;
    always @* begin
        ch7_shared = {NCH{1'b0}};
        for (n = 0; n < NCH; n = n + 1) begin
            if (capture_compare_select_reg[NCH-1] &&
                capture_compare_select_reg[n] &&
                ch7_compare_mask_reg[n]) begin
                ch7_shared[n] = 1'b1;
            end
        end
    end

    always @* begin
        flag_clear = 8'h00;
        if (wen && wr_idx == `TCAEC_IDX_FLAGS)
            flag_clear = wr_byte;
    end

    // channel compare action, ch7 sharing and capture edges
    always @* begin
        act_pairs = {compare_action_ctrl_hi_reg, compare_action_ctrl_lo_reg};
        edge_pairs = {capture_edge_ctrl_hi_reg, capture_edge_ctrl_lo_reg};
        compare_channel_output_next = compare_channel_output_reg;
        capture_next = 8'h00;
        act = 2'b00;
        edg = 2'b00;
        own_hit = 1'b0;
        ch7_hit = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        for (i = 0; i < NCH; i = i + 1) begin
            act = act_pairs[2*i +: 2];
            edg = edge_pairs[2*i +: 2];
            // own action and ch7 event, each gated by the sharing masks
            own_hit = cmp_event[i] & own_allowed[i];
            ch7_hit = compare_match[NCH-1] &
                      ch7_shared[i];
            if (own_hit) begin
                case (act)
                    `TCAEC_ACT_NONE: ;
                    `TCAEC_ACT_TOGGLE:
                        compare_channel_output_next[i] =
                            ~compare_channel_output_reg[i];
                    `TCAEC_ACT_CLEAR:
                        compare_channel_output_next[i] = 1'b0;
                    `TCAEC_ACT_SET:
                        compare_channel_output_next[i] = 1'b1;
                    default: ;
                endcase
            end
            // overflow toggle outranks own action, not the ch7 event
            if (ovf_toggle_hit[i])
                compare_channel_output_next[i] =
                    ~compare_channel_output_reg[i];
            if (ch7_hit)
                compare_channel_output_next[i] = ch7_compare_data_reg[i];
            rise = ~pin_prev_reg[i] & channel_pin_in[i];
            fall = pin_prev_reg[i] & ~channel_pin_in[i];
            case (edg)
                `TCAEC_EDGE_OFF: capture_next[i] = 1'b0;
                `TCAEC_EDGE_RISE: capture_next[i] = rise;
                `TCAEC_EDGE_FALL: capture_next[i] = fall;
                `TCAEC_EDGE_ANY: capture_next[i] = rise | fall;
                default: capture_next[i] = 1'b0;
            endcase
            capture_next[i] = capture_next[i] & capture_mode[i];
        end
        // set wins over a software clear in the same cycle
        channel_flag_next = (channel_flag_reg & ~flag_clear) |
                            capture_next |
                            cmp_event;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            compare_channel_output_reg <= `TCAEC_RST_BYTE;
            channel_flag_reg <= `TCAEC_RST_BYTE;
            pin_prev_reg <= `TCAEC_RST_BYTE;
            capture_event <= `TCAEC_RST_BYTE;
        end else begin
            compare_channel_output_reg <= compare_channel_output_next;
            channel_flag_reg <= channel_flag_next;
            pin_prev_reg <= channel_pin_in;
            capture_event <= capture_next;
        end
    end

    // pin ownership: compare logic when a compare-mode channel is active or masked and not disconnected, else the port
    // own_active marks a channel whose mode and level pair is not 00
    reg [NCH-1:0] own_active;
    reg [NCH-1:0] cmp_owns;
    integer j;
    always @* begin
        own_active = {NCH{1'b0}};
        cmp_owns = {NCH{1'b0}};
        for (j = 0; j < NCH; j = j + 1) begin
            own_active[j] = |act_pairs[2*j +: 2];
            if (capture_compare_select_reg[j] &&
                (own_active[j] || ch7_compare_mask_reg[j])) begin
                cmp_owns[j] = 1'b1;
            end
            // a set disconnect bit hands the pin back to the port
            if (compare_pin_disconnect_reg[j]) begin
                cmp_owns[j] = 1'b0;
            end
        end
    end
    // unowned pins follow the general-purpose port
    assign channel_pin_out = (cmp_owns & compare_channel_output_next) |
                             (~cmp_owns & port_data_out);
    assign channel_pin_oe = cmp_owns | port_dir_out;
    assign channel_irq = channel_flag_reg & channel_irq_enable_reg;

    // read channel
    wire [3:0] rd_idx;
    assign rd_idx = s_axi_araddr[5:2];
    assign s_axi_arready = ~s_axi_rvalid;
    reg [7:0] rd_byte;
    always @* begin
        case (rd_idx)
            `TCAEC_IDX_ACT_HI: rd_byte = compare_action_ctrl_hi_reg;
            `TCAEC_IDX_ACT_LO: rd_byte = compare_action_ctrl_lo_reg;
            `TCAEC_IDX_EDGE_HI: rd_byte = capture_edge_ctrl_hi_reg;
            `TCAEC_IDX_EDGE_LO: rd_byte = capture_edge_ctrl_lo_reg;
            `TCAEC_IDX_IRQ_EN: rd_byte = channel_irq_enable_reg;
            `TCAEC_IDX_SELECT: rd_byte = capture_compare_select_reg;
            `TCAEC_IDX_CH7_MASK: rd_byte = ch7_compare_mask_reg;
            `TCAEC_IDX_CH7_DATA: rd_byte = ch7_compare_data_reg;
            `TCAEC_IDX_PIN_DISC: rd_byte = compare_pin_disconnect_reg;
            `TCAEC_IDX_TOGGLE: rd_byte = overflow_toggle_reg;
            `TCAEC_IDX_FLAGS: rd_byte = channel_flag_reg;
            `TCAEC_IDX_STATUS: rd_byte = compare_channel_output_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TCAEC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00 &&
                            is_mapped(rd_idx)) ?
                           `TCAEC_RESP_OKAY : `TCAEC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // tcaec_timer_channel_ctrl
`default_nettype wire

// *** tcaec_defines.vh ***
/*
 * register offsets, field positions and reset values for the timer
 * channel action and edge control block.
 * assumes byte addresses on a 32-bit axi4-lite bus, one register a word.
 */
`ifndef TCAEC_DEFINES_VH
`define TCAEC_DEFINES_VH

// printed offsets are not all multiples of four: kept as indices
`define TCAEC_IDX_ACT_HI 4'h8
`define TCAEC_IDX_EDGE_HI 4'ha
`define TCAEC_IDX_EDGE_LO 4'hb
`define TCAEC_IDX_IRQ_EN 4'hc
`define TCAEC_IDX_ACT_LO 4'h9
`define TCAEC_IDX_SELECT 4'h0
`define TCAEC_IDX_CH7_MASK 4'h1
`define TCAEC_IDX_CH7_DATA 4'h2
`define TCAEC_IDX_PIN_DISC 4'h3
`define TCAEC_IDX_TOGGLE 4'h4
`define TCAEC_IDX_FLAGS 4'h5
`define TCAEC_IDX_STATUS 4'h6

`define TCAEC_RST_BYTE 8'h00
`define TCAEC_RESP_OKAY 2'b00
`define TCAEC_RESP_SLVERR 2'b10

`define TCAEC_EDGE_OFF 2'b00
`define TCAEC_EDGE_RISE 2'b01
`define TCAEC_EDGE_FALL 2'b10
`define TCAEC_EDGE_ANY 2'b11

`define TCAEC_ACT_NONE 2'b00
`define TCAEC_ACT_TOGGLE 2'b01
`define TCAEC_ACT_CLEAR 2'b10
`define TCAEC_ACT_SET 2'b11

`endif

// *** tcaec_props.sv ***
/* port checker for the timer channel control block
   assumes one aclk domain and aresetn synchronous active low */
`timescale 1ns/100ps
`default_nettype none
module tcaec_props #(parameter NCH = 8) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH-1:0] channel_pin_in,
    input wire logic [NCH-1:0] port_data_out,
    input wire logic [NCH-1:0] port_dir_out,
    input wire logic [NCH-1:0] channel_pin_out,
    input wire logic [NCH-1:0] channel_pin_oe,
    input wire logic [NCH-1:0] capture_event
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write answer late");
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    chk_ar_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    chk_aw_blocked: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    chk_reset_idle: assert property (
        !$past(aresetn) |-> channel_pin_oe == port_dir_out
        && channel_pin_out == port_data_out) else $error("pins not idle");
    chk_capture_cause: assert property (
        (capture_event & ~(($past(channel_pin_in) ^ $past(channel_pin_in, 2))
        | ($past(channel_pin_in, 2) ^ $past(channel_pin_in, 3)))) == '0)
        else $error("capture without pin change");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (|capture_event);
endmodule // tcaec_props
bind tcaec_timer_channel_ctrl tcaec_props #(.NCH(NCH)) u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .channel_pin_in(channel_pin_in),
    .port_data_out(port_data_out), .port_dir_out(port_dir_out),
    .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
    .capture_event(capture_event)
);
`default_nettype wire

// *** tcaec_pin_model.sv ***
/* outside world on the timer channel pins
   assumes the bench sets the outside level of every undriven pin */
`timescale 1ns/100ps
`default_nettype none
module tcaec_pin_model #(parameter NCH = 8) (
    input wire logic [NCH-1:0] pin_out,
    input wire logic [NCH-1:0] pin_oe,
    input wire logic [NCH-1:0] ext_level,
    output logic [NCH-1:0] pin_in
);
    // a driven pin shows the device level, else the outside level
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // tcaec_pin_model
`default_nettype wire

// *** timer_channel_action_edge_ctrl_tb.sv ***
/* self-checking bench for the timer channel control block
   assumes the pin model closes the pins and the checker is bound */
`timescale 1ns/100ps
`default_nettype none
`include "tcaec_defines.vh"
module timer_channel_action_edge_ctrl_tb;
    localparam logic [1:0] rok = `TCAEC_RESP_OKAY;
    localparam logic [1:0] rerr = `TCAEC_RESP_SLVERR;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] match = 8'h00;
    logic [7:0] ext = 8'h00;
    logic [7:0] ovf = 8'h00;
    logic [7:0] pin_in, pin_out, pin_oe, cap, irq;
    int failures = 0;
    int num_checks = 0;
    always #5 aclk = ~aclk;
    tcaec_timer_channel_ctrl #(.NCH(8)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .compare_match(match), .counter_overflow(ovf),
        .channel_pin_in(pin_in), .port_data_out(8'ha5),
        .port_dir_out(8'h00), .channel_pin_out(pin_out),
        .channel_pin_oe(pin_oe), .capture_event(cap), .channel_irq(irq)
    );
    tcaec_pin_model #(.NCH(8)) u_pins (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in)
    );
    task automatic chk(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // wr, rd, pulse and edge_in start after a rising edge and return at a falling one
    task automatic wr(input logic [3:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(a && w)) begin
            @(negedge aclk);
            a = a | (awvalid & awready);
            w = w | (wvalid & wready);
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        @(negedge aclk);
        while (!bvalid) @(negedge aclk);
        chk("bresp", bresp, er);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge aclk);
        while (!arready) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        while (!rvalid) @(negedge aclk);
        chk("rresp", rresp, er);
        if (er === rok) chk("rdata", rdata, {24'h000000, d});
    endtask
    task automatic pulse(input logic [7:0] m, sel, exp);
        @(posedge aclk);
        match <= m;
        @(negedge aclk);
        chk("pin_out", pin_out & sel, exp);
        @(posedge aclk);
        match <= 8'h00;
        @(negedge aclk);
        chk("pin_hold", pin_out & sel, exp);
    endtask
    task automatic edge_in(input logic [7:0] v, exp);
        logic [7:0] seen;
        seen = 8'h00;
        @(posedge aclk);
        ext <= v;
        repeat (4) begin
            @(negedge aclk);
            seen = seen | cap;
        end
        chk("capture", seen, exp);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge aclk);
        failures++;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`TCAEC_IDX_EDGE_HI, 8'h00, rok);
        rd(`TCAEC_IDX_EDGE_LO, 8'h00, rok);
        rd(`TCAEC_IDX_IRQ_EN, 8'h00, rok);
        wr(`TCAEC_IDX_IRQ_EN, 8'ha5, rok);
        rd(`TCAEC_IDX_IRQ_EN, 8'ha5, rok);
        wr(4'hf, 8'h11, rerr);
        rd(4'hf, 8'h00, rerr);
        $display("test registers done");
        wr(`TCAEC_IDX_SELECT, 8'hff, rok);
        wr(`TCAEC_IDX_ACT_LO, 8'he4, rok);
        chk("pin_oe", pin_oe, 8'h0e);
        pulse(8'h0f, 8'h0f, 8'h0b);
        wr(`TCAEC_IDX_ACT_LO, 8'h74, rok);
        pulse(8'h0f, 8'h0f, 8'h05);
        wr(`TCAEC_IDX_ACT_LO, 8'he4, rok);
        pulse(8'h0f, 8'h0f, 8'h0b);
        wr(`TCAEC_IDX_TOGGLE, 8'h08, rok);
        @(posedge aclk);
        match <= 8'h08;
        ovf <= 8'h08;
        @(negedge aclk);
        chk("pin_ovf", pin_out & 8'h08, 8'h00);
        @(posedge aclk);
        match <= 8'h00;
        ovf <= 8'h00;
        @(negedge aclk);
        chk("pin_ovf_hold", pin_out & 8'h08, 8'h00);
        wr(`TCAEC_IDX_TOGGLE, 8'h00, rok);
        wr(`TCAEC_IDX_PIN_DISC, 8'h08, rok);
        chk("pin_oe", pin_oe, 8'h06);
        wr(`TCAEC_IDX_PIN_DISC, 8'h00, rok);
        $display("test compare actions done");
        wr(`TCAEC_IDX_ACT_LO, 8'h00, rok);
        wr(`TCAEC_IDX_CH7_MASK, 8'h90, rok);
        wr(`TCAEC_IDX_CH7_DATA, 8'h90, rok);
        wr(`TCAEC_IDX_ACT_HI, 8'h02, rok);
        pulse(8'h80, 8'h90, 8'h90);
        pulse(8'h10, 8'h90, 8'h80);
        pulse(8'h80, 8'h90, 8'h90);
        $display("test channel 7 sharing done");
        wr(`TCAEC_IDX_SELECT, 8'h00, rok);
        wr(`TCAEC_IDX_ACT_HI, 8'h00, rok);
        wr(`TCAEC_IDX_CH7_MASK, 8'h00, rok);
        wr(`TCAEC_IDX_EDGE_LO, 8'h39, rok);
        wr(`TCAEC_IDX_IRQ_EN, 8'h01, rok);
        wr(`TCAEC_IDX_FLAGS, 8'hff, rok);
        edge_in(8'h0f, 8'h05);
        chk("irq", irq, 8'h01);
        edge_in(8'h00, 8'h06);
        rd(`TCAEC_IDX_FLAGS, 8'h07, rok);
        wr(`TCAEC_IDX_IRQ_EN, 8'h06, rok);
        chk("irq", irq, 8'h06);
        wr(`TCAEC_IDX_FLAGS, 8'hff, rok);
        chk("irq", irq, 8'h00);
        $display("test capture and interrupts done");
        give_verdict;
    end
endmodule // timer_channel_action_edge_ctrl_tb
`default_nettype wire
